// file: logic/ssf_pkg.sv
`default_nettype none
package ssf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W  = 12;
  localparam int CMP_W  = 16;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_DIV     = 8'h04;
  localparam logic [7:0] OFF_RX_CLK  = 8'h10;
  localparam logic [7:0] OFF_RX_FRM  = 8'h14;
  localparam logic [7:0] OFF_TX_CLK  = 8'h18;
  localparam logic [7:0] OFF_TX_FRM  = 8'h1C;
  localparam logic [7:0] OFF_RX_HOLD = 8'h20;
  localparam logic [7:0] OFF_TX_HOLD = 8'h24;
  localparam logic [7:0] OFF_RX_CMP  = 8'h38;
  localparam logic [7:0] OFF_STATUS  = 8'h40;
  localparam logic [7:0] OFF_MASK    = 8'h4C;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  localparam int CTRL_RX_EN    = 0;
  localparam int CTRL_TX_EN    = 8;
  localparam int ST_TX_READY   = 0;
  localparam int ST_TX_EMPTY   = 1;
  localparam int ST_RX_READY   = 4;
  localparam int ST_RX_OVERRUN = 5;
  localparam int HALF_TX       = 0;
  localparam int HALF_RX       = 1;

  typedef enum logic [1:0] {CKS_DIV, CKS_OTHER, CKS_PIN, CKS_NONE} ssf_clk_src_t;
  typedef enum logic [1:0] {CKO_NONE, CKO_CONT, CKO_XFER, CKO_RSVD} ssf_clk_out_t;
  typedef enum logic [3:0] {
    STA_CONT, STA_SYNC, STA_FS_LOW, STA_FS_HIGH, STA_FS_FALL,
    STA_FS_RISE, STA_FS_CHANGE, STA_FS_EDGE, STA_CMP
  } ssf_start_t;
  typedef enum logic [2:0] {
    FS_INPUT, FS_NEG_PULSE, FS_POS_PULSE, FS_LOW_DATA, FS_HIGH_DATA, FS_TOGGLE
  } ssf_frame_output_select_t;

  typedef struct packed {
    logic [7:0]   period;
    logic [11:0]  rsvd_hi;
    ssf_start_t   start;
    logic [2:0]   rsvd_lo;
    logic         clock_invert;
    ssf_clk_out_t clock_output_mode;
    ssf_clk_src_t clock_source_select;
  } ssf_clk_mode_t;

  typedef struct packed {
    logic [4:0] rsvd_hi;
    ssf_frame_output_select_t  frame_output_select;
    logic [7:0] frame_pulse_length;
    logic [3:0] rsvd_mid;
    logic [3:0] datnb;
    logic       msbf;
    logic [1:0] rsvd_lo;
    logic [4:0] datlen;
  } ssf_frm_mode_t;

  typedef struct packed {
    logic clk_o;
    logic clk_oe_n;
    logic fs_o;
    logic fs_oe_n;
  } ssf_pins_t;
endpackage
`default_nettype wire

// file: logic/ssf_core.sv
// Notes on behaviour
// - Divider value is a 12-bit field, largest value 4095.
// - Divider value zero holds the divider idle with no divided clock.
// - Each divided clock level lasts divider value master clock periods.
// - One divided clock is offered to both transmitter and receiver.
// - Transmit clock comes from its pin, the receive clock or the divider.
// - Receive clock comes from its pin, the transmit clock or the divider.
// - Transmit clock inversion affects internal use only, not the pin output.
// - Receive clock inversion affects internal use only, not the pin output.
// - Each clock pin is driven continuously, only during transfer, or not.
// - Either half may run from the other's clock and start with it.
// - A frame begins on a start event, then data words follow.
// - Holding word moves into a shift register and shifts out per format.
// - Ready set on holding-to-shift move; empty when both are empty.
// - Full receive shift register is copied to holding, ready is set.
// - Word completing before holding is read sets overrun and overwrites.
// - Continuous start: transmit on written word, receive once enabled.
// - Start on frame pin edges, levels, changes, or with the other half.
// - Receiver may start when the compare pattern is seen.
// - Frame pin output: level during data, pulse before data, or toggle.
// - Pulse length 1 to 256 bit times, repeated by a period field.
// - Interrupt output is high while any unmasked status event is pending.
`default_nettype none
module ssf_core #(
  parameter int DIV_W = ssf_pkg::DIV_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              tx_clock_pin_i,
  input  wire logic              rx_clock_pin_i,
  input  wire logic              tx_frame_pin_i,
  input  wire logic              rx_frame_pin_i,
  input  wire logic              rx_data_pin_i,
  output logic                   tx_data_pin_o,
  output ssf_pkg::ssf_pins_t     tx_pins,
  output ssf_pkg::ssf_pins_t     rx_pins,
  output logic                   irq
);

  if (DIV_W < 1 || DIV_W > 16)
  begin : g_chk
    $error("DIV_W must lie between 1 and 16");
  end

  // Configuration and status registers
  logic [31:0]             ctrl_reg;
  logic [DIV_W-1:0]        div_reg;
  ssf_pkg::ssf_clk_mode_t  clk_mode_reg [2];
  ssf_pkg::ssf_frm_mode_t  frm_mode_reg [2];
  logic [15:0]             rx_cmp_reg;
  logic [31:0]             mask_reg;
  logic [31:0]             rdata_reg;
  logic                    irq_reg;

  // Divider
  logic [DIV_W-1:0]        div_cnt_reg;
  logic                    div_clk_reg;

  // Pin synchronisers: 0 tx clock, 1 rx clock, 2 tx frame, 3 rx frame, 4 rx data
  logic [4:0]              pin_raw;
  logic [4:0]              s1_reg;
  logic [4:0]              s2_reg;
  logic [4:0]              s3_reg;
  logic [4:0]              pin_lvl_reg;

  // Per half state, index 0 transmitter, 1 receiver
  logic [1:0]              src_lvl_reg;
  logic [1:0]              int_prev_reg;
  logic [1:0]              active_reg;
  logic [1:0]              fs_prev_reg;
  logic [1:0]              fs_tgl_reg;
  logic [1:0]              fs_o_reg;
  logic [1:0]              clk_o_reg;
  logic [4:0]              bit_cnt_reg  [2];
  logic [3:0]              word_cnt_reg [2];
  logic [8:0]              per_cnt_reg  [2];
  logic [8:0]              pulse_cnt_reg [2];
  logic [1:0]              tick;
  logic [1:0]              start_ev;
  logic [1:0]              half_en;
  logic [1:0]              cont_go;
  logic [1:0]              last_bit;
  logic [1:0]              last_word;
  ssf_pkg::ssf_pins_t      pins_out [2];

  // Data path
  logic [31:0]             tx_hold_reg;
  logic                    tx_hold_valid_reg;
  logic [31:0]             tx_shift_reg;
  logic                    tx_data_reg;
  logic [31:0]             rx_shift_reg;
  logic [31:0]             rx_next;
  logic [31:0]             rx_hold_reg;
  logic                    rx_ready_reg;
  logic                    rx_overrun_reg;
  logic [15:0]             rx_hist_reg;

  // Bus decode
  wire bus_wr       = reg_wr & clk_en;
  wire bus_rd       = reg_rd & clk_en;
  wire hit_ctrl     = reg_addr == ssf_pkg::OFF_CTRL;
  wire hit_div      = reg_addr == ssf_pkg::OFF_DIV;
  wire hit_rx_clk   = reg_addr == ssf_pkg::OFF_RX_CLK;
  wire hit_rx_frm   = reg_addr == ssf_pkg::OFF_RX_FRM;
  wire hit_tx_clk   = reg_addr == ssf_pkg::OFF_TX_CLK;
  wire hit_tx_frm   = reg_addr == ssf_pkg::OFF_TX_FRM;
  wire hit_rx_hold  = reg_addr == ssf_pkg::OFF_RX_HOLD;
  wire hit_tx_hold  = reg_addr == ssf_pkg::OFF_TX_HOLD;
  wire hit_rx_cmp   = reg_addr == ssf_pkg::OFF_RX_CMP;
  wire hit_status   = reg_addr == ssf_pkg::OFF_STATUS;
  wire hit_mask     = reg_addr == ssf_pkg::OFF_MASK;
  wire tx_hold_wr   = bus_wr & hit_tx_hold;
  wire rx_hold_rd   = bus_rd & hit_rx_hold;
  wire status_rd    = bus_rd & hit_status;

  wire tx_empty = ~tx_hold_valid_reg & ~active_reg[ssf_pkg::HALF_TX];
  wire tx_ready = ~tx_hold_valid_reg;

  wire [31:0] status_word = {26'h000_0000, rx_overrun_reg, rx_ready_reg,
                             2'b00, tx_empty, tx_ready};

  wire [31:0] rd_mux =
    hit_ctrl    ? ctrl_reg :
    hit_div     ? {{(32-DIV_W){1'b0}}, div_reg} :
    hit_rx_clk  ? 32'(clk_mode_reg[ssf_pkg::HALF_RX]) :
    hit_rx_frm  ? 32'(frm_mode_reg[ssf_pkg::HALF_RX]) :
    hit_tx_clk  ? 32'(clk_mode_reg[ssf_pkg::HALF_TX]) :
    hit_tx_frm  ? 32'(frm_mode_reg[ssf_pkg::HALF_TX]) :
    hit_rx_hold ? rx_hold_reg :
    hit_rx_cmp  ? {16'h0000, rx_cmp_reg} :
    hit_status  ? status_word :
    hit_mask    ? mask_reg :
    ssf_pkg::RST_WORD;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_reg     <= ssf_pkg::RST_WORD;
      div_reg      <= '0;
      clk_mode_reg <= '{default: '0};
      frm_mode_reg <= '{default: '0};
      rx_cmp_reg   <= '0;
      mask_reg     <= ssf_pkg::RST_WORD;
      rdata_reg    <= ssf_pkg::RST_WORD;
      irq_reg      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (bus_wr & hit_ctrl)
        ctrl_reg <= reg_wdata;
      if (bus_wr & hit_div)
        div_reg <= reg_wdata[DIV_W-1:0];
      if (bus_wr & hit_rx_clk)
        clk_mode_reg[ssf_pkg::HALF_RX] <= ssf_pkg::ssf_clk_mode_t'(reg_wdata);
      if (bus_wr & hit_rx_frm)
        frm_mode_reg[ssf_pkg::HALF_RX] <= ssf_pkg::ssf_frm_mode_t'(reg_wdata);
      if (bus_wr & hit_tx_clk)
        clk_mode_reg[ssf_pkg::HALF_TX] <= ssf_pkg::ssf_clk_mode_t'(reg_wdata);
      if (bus_wr & hit_tx_frm)
        frm_mode_reg[ssf_pkg::HALF_TX] <= ssf_pkg::ssf_frm_mode_t'(reg_wdata);
      if (bus_wr & hit_rx_cmp)
        rx_cmp_reg <= reg_wdata[15:0];
      if (bus_wr & hit_mask)
        mask_reg <= reg_wdata;
      // Data stand only in the cycle after the read strobe
      rdata_reg <= bus_rd ? rd_mux : ssf_pkg::RST_WORD;
      irq_reg   <= |(status_word & mask_reg);
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = irq_reg;

  // Divider: shared by both halves
  wire [DIV_W-1:0] div_last = DIV_W'(div_reg - 1'b1);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_cnt_reg <= '0;
      div_clk_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (div_reg == '0)
      begin
        div_cnt_reg <= '0;
        div_clk_reg <= 1'b0;
      end
      else if (div_cnt_reg >= div_last)
      begin
        div_cnt_reg <= '0;
        div_clk_reg <= ~div_clk_reg;
      end
      else
        div_cnt_reg <= DIV_W'(div_cnt_reg + 1'b1);
    end
  end

  // Pins settle when the second and third stage agree
  assign pin_raw = {rx_data_pin_i, rx_frame_pin_i, tx_frame_pin_i,
                    rx_clock_pin_i, tx_clock_pin_i};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_reg      <= '0;
      s2_reg      <= '0;
      s3_reg      <= '0;
      pin_lvl_reg <= '0;
    end
    else if (clk_en)
    begin
      s1_reg      <= pin_raw;
      s2_reg      <= s1_reg;
      s3_reg      <= s2_reg;
      pin_lvl_reg <= (s2_reg & s3_reg) | (pin_lvl_reg & (s2_reg ^ s3_reg));
    end
  end

  assign half_en = {ctrl_reg[ssf_pkg::CTRL_RX_EN], ctrl_reg[ssf_pkg::CTRL_TX_EN]};
  assign cont_go = {half_en[ssf_pkg::HALF_RX], tx_hold_valid_reg};

  // Compare pattern: length follows the frame pulse length field, capped at 16 bits
  wire [7:0]  rx_frame_pulse_length = frm_mode_reg[ssf_pkg::HALF_RX].frame_pulse_length;
  wire [3:0]  cmp_top  = (|rx_frame_pulse_length[7:4]) ? 4'hF : rx_frame_pulse_length[3:0];
  wire [15:0] cmp_mask = 16'hFFFF >> (4'hF - cmp_top);
  wire        cmp_hit  = ((rx_hist_reg ^ rx_cmp_reg) & cmp_mask) == 16'h0000;

  for (genvar h = 0; h < 2; h++)
  begin : g_half
    localparam int O = 1 - h;
    ssf_pkg::ssf_clk_mode_t cm;
    ssf_pkg::ssf_frm_mode_t fm;
    logic                   src;
    logic                   int_lvl;
    logic                   fs_lvl;
    logic                   go;
    logic                   pulse_on;
    logic                   fs_next;

    assign cm = clk_mode_reg[h];
    assign fm = frm_mode_reg[h];

    // Other half's source is taken registered so two cross selections form no loop
    assign src =
      (cm.clock_source_select == ssf_pkg::CKS_DIV)   ? div_clk_reg :
      (cm.clock_source_select == ssf_pkg::CKS_OTHER) ? src_lvl_reg[O] :
      (cm.clock_source_select == ssf_pkg::CKS_PIN)   ? pin_lvl_reg[h] :
      1'b0;

    assign int_lvl = src_lvl_reg[h] ^ cm.clock_invert;

    // Transmitter drives on falling internal edges, receiver samples on rising
    assign tick[h] = (h == ssf_pkg::HALF_TX) ? (int_prev_reg[h] & ~int_lvl)
                                             : (~int_prev_reg[h] & int_lvl);

    assign fs_lvl = (fm.frame_output_select == ssf_pkg::FS_INPUT) ? pin_lvl_reg[2+h] : fs_o_reg[h];

    always_comb
    begin
      unique case (cm.start)
        ssf_pkg::STA_CONT:      go = cont_go[h];
        ssf_pkg::STA_SYNC:      go = active_reg[O];
        ssf_pkg::STA_FS_LOW:    go = ~fs_lvl;
        ssf_pkg::STA_FS_HIGH:   go = fs_lvl;
        ssf_pkg::STA_FS_FALL:   go = fs_prev_reg[h] & ~fs_lvl;
        ssf_pkg::STA_FS_RISE:   go = ~fs_prev_reg[h] & fs_lvl;
        ssf_pkg::STA_FS_CHANGE: go = fs_prev_reg[h] ^ fs_lvl;
        ssf_pkg::STA_FS_EDGE:   go = fs_prev_reg[h] ^ fs_lvl;
        ssf_pkg::STA_CMP:       go = (h == ssf_pkg::HALF_RX) & cmp_hit;
        default:                go = 1'b0;
      endcase
    end

    assign start_ev[h]  = tick[h] & half_en[h] & ~active_reg[h] & go;
    assign last_bit[h]  = bit_cnt_reg[h] == fm.datlen;
    assign last_word[h] = word_cnt_reg[h] == fm.datnb;
    assign pulse_on     = pulse_cnt_reg[h] != 9'h000;

    always_comb
    begin
      unique case (fm.frame_output_select)
        ssf_pkg::FS_NEG_PULSE: fs_next = ~pulse_on;
        ssf_pkg::FS_POS_PULSE: fs_next = pulse_on;
        ssf_pkg::FS_LOW_DATA:  fs_next = ~active_reg[h];
        ssf_pkg::FS_HIGH_DATA: fs_next = active_reg[h];
        ssf_pkg::FS_TOGGLE:    fs_next = fs_tgl_reg[h];
        default:               fs_next = 1'b0;
      endcase
    end

    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        src_lvl_reg[h]   <= 1'b0;
        int_prev_reg[h]  <= 1'b0;
        active_reg[h]    <= 1'b0;
        fs_prev_reg[h]   <= 1'b0;
        fs_tgl_reg[h]    <= 1'b0;
        fs_o_reg[h]      <= 1'b0;
        clk_o_reg[h]     <= 1'b0;
        bit_cnt_reg[h]   <= '0;
        word_cnt_reg[h]  <= '0;
        per_cnt_reg[h]   <= '0;
        pulse_cnt_reg[h] <= '0;
      end
      else if (clk_en)
      begin
        src_lvl_reg[h]  <= src;
        int_prev_reg[h] <= int_lvl;
        fs_o_reg[h]     <= fs_next;
        if (tick[h])
          fs_prev_reg[h] <= fs_lvl;
        if (!half_en[h])
          active_reg[h] <= 1'b0;
        else if (start_ev[h])
        begin
          active_reg[h]   <= 1'b1;
          bit_cnt_reg[h]  <= '0;
          word_cnt_reg[h] <= '0;
          fs_tgl_reg[h]   <= ~fs_tgl_reg[h];
        end
        else if (tick[h] && active_reg[h])
        begin
          if (last_bit[h])
          begin
            bit_cnt_reg[h] <= '0;
            if (last_word[h])
              active_reg[h] <= 1'b0;
            else
              word_cnt_reg[h] <= word_cnt_reg[h] + 4'h1;
          end
          else
            bit_cnt_reg[h] <= bit_cnt_reg[h] + 5'h01;
        end
        // Pulse train: period field gives 2*(period+1) bit times, zero stops it
        if (!half_en[h] || cm.period == 8'h00)
        begin
          per_cnt_reg[h]   <= '0;
          pulse_cnt_reg[h] <= '0;
        end
        else if (tick[h])
        begin
          if (per_cnt_reg[h] == 9'h000)
          begin
            per_cnt_reg[h]   <= {cm.period, 1'b1};
            pulse_cnt_reg[h] <= {1'b0, fm.frame_pulse_length} + 9'h001;
          end
          else
          begin
            per_cnt_reg[h] <= per_cnt_reg[h] - 9'h001;
            if (pulse_on)
              pulse_cnt_reg[h] <= pulse_cnt_reg[h] - 9'h001;
          end
        end
        unique case (cm.clock_output_mode)
          ssf_pkg::CKO_CONT: clk_o_reg[h] <= src_lvl_reg[h];
          ssf_pkg::CKO_XFER: clk_o_reg[h] <= src_lvl_reg[h] & active_reg[h];
          default:           clk_o_reg[h] <= 1'b0;
        endcase
      end
    end

    assign pins_out[h] = '{clk_o:    clk_o_reg[h],
                           clk_oe_n: cm.clock_output_mode == ssf_pkg::CKO_NONE,
                           fs_o:     fs_o_reg[h],
                           fs_oe_n:  fm.frame_output_select == ssf_pkg::FS_INPUT};
  end

  assign tx_pins = pins_out[ssf_pkg::HALF_TX];
  assign rx_pins = pins_out[ssf_pkg::HALF_RX];

  // Transmit path
  wire [4:0] tx_len  = frm_mode_reg[ssf_pkg::HALF_TX].datlen;
  wire       tx_msbf = frm_mode_reg[ssf_pkg::HALF_TX].msbf;
  wire       tx_tick = tick[ssf_pkg::HALF_TX] & active_reg[ssf_pkg::HALF_TX];
  wire       tx_load = start_ev[ssf_pkg::HALF_TX] |
                       (tx_tick & last_bit[ssf_pkg::HALF_TX] & ~last_word[ssf_pkg::HALF_TX]);
  wire       tx_bit  = tx_msbf ? tx_shift_reg[tx_len] : tx_shift_reg[0];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_hold_reg       <= '0;
      tx_hold_valid_reg <= 1'b0;
      tx_shift_reg      <= '0;
      tx_data_reg       <= 1'b0;
    end
    else if (clk_en)
    begin
      // A write in the move cycle refills holding, the old word goes out
      if (tx_hold_wr)
      begin
        tx_hold_reg       <= reg_wdata;
        tx_hold_valid_reg <= 1'b1;
      end
      else if (tx_load)
        tx_hold_valid_reg <= 1'b0;
      // Underrun sends zeros rather than stalling the frame
      if (tx_load)
        tx_shift_reg <= tx_hold_valid_reg ? tx_hold_reg : '0;
      else if (tx_tick)
        tx_shift_reg <= tx_msbf ? {tx_shift_reg[30:0], 1'b0}
                                : {1'b0, tx_shift_reg[31:1]};
      if (tx_tick)
        tx_data_reg <= tx_bit;
      else if (tick[ssf_pkg::HALF_TX])
        tx_data_reg <= 1'b0;
    end
  end

  assign tx_data_pin_o = tx_data_reg;

  // Receive path
  wire [4:0] rx_len  = frm_mode_reg[ssf_pkg::HALF_RX].datlen;
  wire       rx_msbf = frm_mode_reg[ssf_pkg::HALF_RX].msbf;
  wire       rx_d    = pin_lvl_reg[4];
  wire       rx_tick = tick[ssf_pkg::HALF_RX] & active_reg[ssf_pkg::HALF_RX];
  wire       rx_done = rx_tick & last_bit[ssf_pkg::HALF_RX];
  wire [31:0] rx_wmask = 32'hFFFF_FFFF >> (5'h1F - rx_len);

  always_comb
  begin
    rx_next = rx_msbf ? {rx_shift_reg[30:0], rx_d} : {1'b0, rx_shift_reg[31:1]};
    if (!rx_msbf)
      rx_next[rx_len] = rx_d;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_shift_reg   <= '0;
      rx_hold_reg    <= '0;
      rx_ready_reg   <= 1'b0;
      rx_overrun_reg <= 1'b0;
      rx_hist_reg    <= '0;
    end
    else if (clk_en)
    begin
      if (rx_tick)
        rx_shift_reg <= rx_next;
      if (tick[ssf_pkg::HALF_RX] && half_en[ssf_pkg::HALF_RX])
        rx_hist_reg <= {rx_hist_reg[14:0], rx_d};
      if (rx_done)
        rx_hold_reg <= rx_next & rx_wmask;
      // Setting wins over the clear by a read in the same cycle
      rx_ready_reg   <= rx_done | (rx_ready_reg & ~rx_hold_rd);
      rx_overrun_reg <= (rx_done & rx_ready_reg & ~rx_hold_rd) |
                        (rx_overrun_reg & ~status_rd);
    end
  end

endmodule
`default_nettype wire

// file: testbench/ssf_core_asserts.sv
`default_nettype none
module ssf_core_asserts #(
  parameter int DIV_W = ssf_pkg::DIV_W
) (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               clk_en,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire ssf_pkg::ssf_pins_t tx_pins,
  input wire ssf_pkg::ssf_pins_t rx_pins,
  input wire logic               irq
);
  logic [DIV_W-1:0] dv_reg;
  logic [3:0]       tcm_reg;
  logic [3:0]       dz_reg;
  logic [3:0]       idle_reg;
  logic [1:0]       tog_reg;
  logic [12:0]      run_reg;
  logic             prev_reg;
  logic             txen_reg;
  logic             mz_reg;
  wire logic        wr_on  = reg_wr && clk_en;
  wire logic        wr_div = wr_on && reg_addr == ssf_pkg::OFF_DIV;
  wire logic        wr_tck = wr_on && reg_addr == ssf_pkg::OFF_TX_CLK;
  wire logic        chg    = tx_pins.clk_o != prev_reg;
  // Shadows of written settings let the checker judge the pins alone
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      {dv_reg, tcm_reg, dz_reg, idle_reg, tog_reg, run_reg, prev_reg, txen_reg} <= '0;
      mz_reg <= 1'b1;
    end
    else
    begin
      prev_reg <= tx_pins.clk_o;
      run_reg  <= chg ? 13'h1 : run_reg + 13'h1;
      tog_reg  <= (wr_div || wr_tck) ? 2'h0 : tog_reg + 2'(chg && tog_reg != 2'h3);
      dz_reg   <= (dv_reg == '0 && tcm_reg[1:0] == 2'h0) ? dz_reg + 4'(dz_reg != 4'hF) : 4'h0;
      idle_reg <= (tcm_reg[3:2] == 2'h2 && !txen_reg) ? idle_reg + 4'(idle_reg != 4'hF) : 4'h0;
      if (wr_div) dv_reg <= reg_wdata[DIV_W-1:0];
      if (wr_tck) tcm_reg <= reg_wdata[3:0];
      if (wr_on && reg_addr == ssf_pkg::OFF_CTRL) txen_reg <= reg_wdata[ssf_pkg::CTRL_TX_EN];
      if (wr_on && reg_addr == ssf_pkg::OFF_MASK) mz_reg <= reg_wdata == '0;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_mask_off;
    mz_reg ##1 mz_reg;
  endsequence
  sequence s_cfg_wr(logic [7:0] a);
    wr_on && reg_addr == a;
  endsequence
  chk_div_half: assert property (
    chg && tog_reg >= 2'h2 && dv_reg != '0 && tcm_reg == 4'h4 |-> run_reg == 13'(dv_reg))
    else $error("divided clock level length wrong");
  chk_div_off: assert property (dz_reg == 4'hF |-> $stable(tx_pins.clk_o))
    else $error("divided clock moves while divider is zero");
  chk_xfer_idle: assert property (idle_reg == 4'hF |-> $stable(tx_pins.clk_o))
    else $error("tx clock pin moves outside transfer");
  chk_tx_clk_oe: assert property (s_cfg_wr(ssf_pkg::OFF_TX_CLK) |=>
    tx_pins.clk_oe_n == (($past(reg_wdata) & 32'h0000_000C) == '0))
    else $error("tx clock pin enable wrong");
  chk_rx_clk_oe: assert property (s_cfg_wr(ssf_pkg::OFF_RX_CLK) |=>
    rx_pins.clk_oe_n == (($past(reg_wdata) & 32'h0000_000C) == '0))
    else $error("rx clock pin enable wrong");
  chk_tx_fs_oe: assert property (s_cfg_wr(ssf_pkg::OFF_TX_FRM) |=>
    tx_pins.fs_oe_n == (($past(reg_wdata) & 32'h0700_0000) == '0))
    else $error("tx frame pin enable wrong");
  chk_rx_fs_oe: assert property (s_cfg_wr(ssf_pkg::OFF_RX_FRM) |=>
    rx_pins.fs_oe_n == (($past(reg_wdata) & 32'h0700_0000) == '0))
    else $error("rx frame pin enable wrong");
  chk_irq_masked: assert property (s_mask_off |-> !irq)
    else $error("interrupt high with all events masked");
endmodule
bind ssf_core ssf_core_asserts #(.DIV_W(DIV_W)) ssf_core_asserts_i (
  .ref_clk   (ref_clk),
  .rst       (rst),
  .clk_en    (clk_en),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .tx_pins   (tx_pins),
  .rx_pins   (rx_pins),
  .irq       (irq)
);
`default_nettype wire

// file: testbench/ssf_partner.sv
`default_nettype none
module ssf_partner #(
  parameter int HALF = 10
) (
  input  wire logic ref_clk,
  input  wire logic clk_run,
  input  wire logic tx_data_pin_o,
  output var logic  ext_clk,
  output var logic  rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Bit clock at master/(2*HALF); HALF of 3 or more meets both pin limits
  always @(posedge ref_clk)
  begin
    if (!clk_run)
    begin
      cnt     <= 0;
      ext_clk <= 1'b0;
    end
    else
    begin
      cnt     <= (cnt == HALF - 1) ? 0 : cnt + 1;
      ext_clk <= (cnt == HALF - 1) ? !ext_clk : ext_clk;
    end
  end
  // Loopback codec plays back what it hears one master cycle later
  always @(posedge ref_clk)
    rx_data <= tx_data_pin_o;
endmodule
`default_nettype wire

// file: testbench/ssf_core_tb_top.sv
`default_nettype none
module ssf_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk = 1'b0;
  logic               rst = 1'b1;
  logic               clk_en = 1'b1;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0000_0000;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               clk_run = 1'b0;
  logic [31:0]        reg_rdata;
  logic               tx_data_pin_o;
  logic               ext_clk;
  logic               rx_data;
  logic               irq;
  ssf_pkg::ssf_pins_t tx_pins;
  ssf_pkg::ssf_pins_t rx_pins;
  int                 error_cnt = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  ssf_core #(.DIV_W(ssf_pkg::DIV_W)) ssf_core_i (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .clk_en         (clk_en),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .tx_clock_pin_i (ext_clk),
    .rx_clock_pin_i (1'b0),
    .tx_frame_pin_i (1'b0),
    .rx_frame_pin_i (1'b0),
    .rx_data_pin_i  (rx_data),
    .tx_data_pin_o  (tx_data_pin_o),
    .tx_pins        (tx_pins),
    .rx_pins        (rx_pins),
    .irq            (irq)
  );
  ssf_partner #(.HALF(10)) ssf_partner_i (
    .ref_clk       (ref_clk),
    .clk_run       (clk_run),
    .tx_data_pin_o (tx_data_pin_o),
    .ext_clk       (ext_clk),
    .rx_data       (rx_data)
  );
  initial forever #2 ref_clk = ~ref_clk;
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Longest path is the 4095 divider run, well under this ceiling
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic wait_st(input int b, output logic [31:0] st);
    int n;
    n  = 0;
    st = 32'h0000_0000;
    while (st[b] !== 1'b1 && n < 400)
    begin
      rd(ssf_pkg::OFF_STATUS, st);
      n++;
    end
  endtask
  task automatic wait_lvl(input logic l, output int n);
    n = 0;
    while (tx_pins.clk_o !== l && n < 9000)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic reset_state();
    logic [31:0] st;
    rd(ssf_pkg::OFF_STATUS, st);
    chk(st, 32'h0000_0003);
    rd(8'h08, st);
    chk(st, 32'h0000_0000);
  endtask
  task automatic div_run(input logic [31:0] d, input int e);
    logic [31:0] v;
    int          n;
    wr(ssf_pkg::OFF_DIV, 32'h0000_0000);
    repeat (12) @(negedge ref_clk);
    v = {31'h0, tx_pins.clk_o};
    repeat (20)
    begin
      @(negedge ref_clk);
      chk({31'h0, tx_pins.clk_o}, v);
    end
    wr(ssf_pkg::OFF_DIV, d);
    rd(ssf_pkg::OFF_DIV, v);
    chk(v, 32'(e));
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    n = 0;
    while (tx_pins.clk_o === 1'b1 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(32'(n), 32'(e));
  endtask
  task automatic xfer(input logic [31:0] tcm, input logic [31:0] w);
    logic [31:0] st;
    clk_run <= tcm[1];
    // Pin source goes only with clock output off
    wr(ssf_pkg::OFF_TX_CLK, tcm);
    wr(ssf_pkg::OFF_TX_HOLD, w);
    wait_st(ssf_pkg::ST_RX_READY, st);
    // Stop before the reads: the next call sets it in the same step
    clk_run <= 1'b0;
    chk({31'h0, irq}, 32'h0000_0001);
    rd(ssf_pkg::OFF_RX_HOLD, st);
    chk(st, w);
    rd(ssf_pkg::OFF_STATUS, st);
    chk(st, 32'h0000_0003);
  endtask
  task automatic overrun();
    logic [31:0] st;
    wr(ssf_pkg::OFF_TX_CLK, 32'h0000_0004);
    wr(ssf_pkg::OFF_TX_HOLD, 32'h0000_003C);
    wait_st(ssf_pkg::ST_RX_READY, st);
    wr(ssf_pkg::OFF_TX_HOLD, 32'h0000_005A);
    wait_st(ssf_pkg::ST_RX_OVERRUN, st);
    chk(st & 32'h0000_0030, 32'h0000_0030);
    rd(ssf_pkg::OFF_RX_HOLD, st);
    chk(st, 32'h0000_005A);
    rd(ssf_pkg::OFF_STATUS, st);
    chk(st, 32'h0000_0003);
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    reset_state();
    wr(ssf_pkg::OFF_TX_CLK, 32'h0000_0004);
    div_run(32'h0000_0001, 1);
    div_run(32'h0000_0003, 3);
    div_run(32'h0000_1FFF, 4095);
    wr(ssf_pkg::OFF_RX_CLK, 32'h0000_0101);
    wr(ssf_pkg::OFF_RX_FRM, 32'h0000_0087);
    wr(ssf_pkg::OFF_TX_FRM, 32'h0000_0087);
    wr(ssf_pkg::OFF_MASK, 32'h0000_0010);
    wr(ssf_pkg::OFF_DIV, 32'h0000_0008);
    wr(ssf_pkg::OFF_CTRL, 32'h0000_0101);
    xfer(32'h0000_0004, 32'h0000_00A5);
    xfer(32'h0000_0002, 32'h0000_003C);
    overrun();
    wr(ssf_pkg::OFF_CTRL, 32'h0000_0000);
    wr(ssf_pkg::OFF_TX_CLK, 32'h0000_0008);
    repeat (20) @(posedge ref_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
